// ### mpf_pause_ctrl.sv
// pause-frame receive, pause timer, transmit hold and its interrupts
// assumes the receive pins come straight from the phy, asynchronous to clk_sys,
// with rx clock well below half of clk_sys; tx_active is on clk_sys
`timescale 1ns/1ps
`include "mpf_defines.svh"

// How it works
// [RULE_01] pause candidate: address matches sa1 or multicast
// [RULE_02] valid only with type 8808 and opcode 0001
// [RULE_03] fcs or receive error frames are discarded
// [RULE_04] parse da, sa, type, opcode, pause time
// [RULE_05] valid frame overwrites pause time, any enable
// [RULE_06] load and pause only in full duplex
// [RULE_07] half duplex: no pause, interrupt still raised
// [RULE_08] valid frame sets status bit 12, masked
// [RULE_09] enable and nonzero time hold new frames
// [RULE_10] decrement every 128 rx clocks once stopped
// [RULE_11] retry test: decrement every rx clock
// [RULE_12] enable clear: decrement even while transmitting
// [RULE_13] reaching zero sets status bit 13, masked
// [RULE_14] each valid frame bumps the pause statistic
// [RULE_15] pause time saturates at zero, zero after reset
module mpf_pause_ctrl #(
  parameter int QUANTA_CYCLES = `MPF_QUANTA_RX_CLKS,
  parameter int STAT_W = `MPF_STAT_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic mii_rx_clk,
  input wire logic mii_rx_dv,
  input wire logic mii_rx_er,
  input wire logic [3:0] mii_rxd,
  input wire logic tx_active,
  output logic tx_hold,
  output logic irq
);

  localparam int QW = $clog2(QUANTA_CYCLES + 1);
  // sized copies of wide constants, so single bits and bytes can be picked
  localparam logic [31:0] RST_CFG = `MPF_RST_CFG;
  localparam logic [31:0] RST_IER = `MPF_RST_IER;
  localparam logic [15:0] TYPE_CTRL = `MPF_TYPE_CTRL;
  localparam logic [15:0] OPC_PAUSE = `MPF_OPC_PAUSE;

  // the prescaler needs at least one receive clock per step
  if (QUANTA_CYCLES < 1) begin : g_bad_quanta
    $error("mpf_pause_ctrl: QUANTA_CYCLES must be at least 1");
  end
  // the statistic is read back through one 32-bit word
  if (STAT_W < 1 || STAT_W > 32) begin : g_bad_stat
    $error("mpf_pause_ctrl: STAT_W must lie between 1 and 32");
  end

  // crc-32 over one nibble, lsb first as it leaves the wire
  function automatic logic [31:0] crc_nib(input logic [31:0] c, input logic [3:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 4; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ `MPF_CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  // pin synchronisers; stage 1 feeds stage 2 only
  // clock, valid, error and data share one path so they stay aligned
  mpf_pkg::mpf_mii_t pin_s1;
  mpf_pkg::mpf_mii_t pin_s2;
  logic rxc_s3;
  logic rx_rise;
  logic rx_fall;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      rxc_s3 <= 1'b0;
    end else begin
      pin_s1 <= '{clk: mii_rx_clk, dv: mii_rx_dv, er: mii_rx_er, d: mii_rxd};
      pin_s2 <= pin_s1;
      rxc_s3 <= pin_s2.clk;
    end
  end

  assign rx_rise = pin_s2.clk & ~rxc_s3;
  // data is taken mid-cycle, away from where the phy changes it
  assign rx_fall = ~pin_s2.clk & rxc_s3;

  // registers
  logic cfg_fdx;
  logic cfg_retry;
  logic cfg_pause_en;
  logic [47:0] sa1;
  logic [13:12] ier;
  logic [13:12] isr;
  logic [13:12] next_isr;
  logic [15:0] pause_time;
  logic [15:0] next_pause_time;
  logic [STAT_W-1:0] pause_stat;
  logic [13:12] icr_clr;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg_fdx <= RST_CFG[`MPF_CFG_FDX];
      cfg_retry <= RST_CFG[`MPF_CFG_RETRY];
      cfg_pause_en <= RST_CFG[`MPF_CFG_PAUSE_EN];
      sa1 <= `MPF_RST_SA1;
      ier <= RST_IER[13:12];
    end else if (reg_wr) begin
      unique case (reg_addr)
        `MPF_OFS_CFG: begin
          cfg_fdx <= reg_wdata[`MPF_CFG_FDX];
          cfg_retry <= reg_wdata[`MPF_CFG_RETRY];
          cfg_pause_en <= reg_wdata[`MPF_CFG_PAUSE_EN];
        end
        `MPF_OFS_SA1_LO: sa1[31:0] <= reg_wdata;
        `MPF_OFS_SA1_HI: sa1[47:32] <= reg_wdata[15:0];
        `MPF_OFS_IER: ier <= reg_wdata[13:12];
        default: ;
      endcase
    end
  end

  assign icr_clr = (reg_wr && reg_addr == `MPF_OFS_ICR) ? reg_wdata[13:12] : 2'b00;

  // irq sees an enable write at once, so it never lags the mask by a cycle
  logic [13:12] ier_now;
  assign ier_now = (reg_wr && reg_addr == `MPF_OFS_IER) ? reg_wdata[13:12] : ier;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        unique case (reg_addr)
          `MPF_OFS_CFG: begin
            reg_rdata[`MPF_CFG_FDX] <= cfg_fdx;
            reg_rdata[`MPF_CFG_RETRY] <= cfg_retry;
            reg_rdata[`MPF_CFG_PAUSE_EN] <= cfg_pause_en;
          end
          `MPF_OFS_SA1_LO: reg_rdata <= sa1[31:0];
          `MPF_OFS_SA1_HI: reg_rdata[15:0] <= sa1[47:32];
          `MPF_OFS_PTIME: reg_rdata[15:0] <= pause_time;
          `MPF_OFS_ISR: reg_rdata[13:12] <= isr;
          `MPF_OFS_IER: reg_rdata[13:12] <= ier;
          `MPF_OFS_PSTAT: reg_rdata[STAT_W-1:0] <= pause_stat;
          default: ;
        endcase
      end
    end
  end

  // receive parser
  // pause_valid is a one-cycle strobe shared by timer, status and statistic
  mpf_pkg::mpf_state_t state;
  logic [10:0] byte_idx;
  logic [3:0] nib_lo;
  logic nib_odd;
  logic [31:0] crc;
  logic da_sa1_ok;
  logic da_mc_ok;
  logic hdr_ok;
  logic frame_err;
  logic [15:0] ptime_rx;
  logic pause_valid;
  logic [7:0] rx_byte;
  logic [47:0] mc_addr;

  assign rx_byte = {pin_s2.d, nib_lo};
  assign mc_addr = `MPF_MC_ADDR;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= mpf_pkg::MPF_ST_IDLE;
      byte_idx <= 11'h000;
      nib_lo <= 4'h0;
      nib_odd <= 1'b0;
      crc <= `MPF_CRC_INIT;
      da_sa1_ok <= 1'b0;
      da_mc_ok <= 1'b0;
      hdr_ok <= 1'b0;
      frame_err <= 1'b0;
      ptime_rx <= 16'h0000;
      pause_valid <= 1'b0;
    end else begin
      pause_valid <= 1'b0;
      if (rx_fall) begin
        unique case (state)
          mpf_pkg::MPF_ST_IDLE: begin
            if (pin_s2.dv) begin
              state <= (pin_s2.d == `MPF_NIB_PRE) ? mpf_pkg::MPF_ST_PRE
                                                   : mpf_pkg::MPF_ST_DROP;
            end
          end
          mpf_pkg::MPF_ST_PRE: begin
            if (!pin_s2.dv) begin
              state <= mpf_pkg::MPF_ST_IDLE;
            end else if (pin_s2.d == `MPF_NIB_SFD) begin
              state <= mpf_pkg::MPF_ST_BODY;
              byte_idx <= 11'h000;
              nib_odd <= 1'b0;
              crc <= `MPF_CRC_INIT;
              da_sa1_ok <= 1'b1;
              da_mc_ok <= 1'b1;
              hdr_ok <= 1'b1;
              frame_err <= pin_s2.er;
            end else if (pin_s2.d != `MPF_NIB_PRE) begin
              state <= mpf_pkg::MPF_ST_DROP;
            end
          end
          mpf_pkg::MPF_ST_BODY: begin
            if (!pin_s2.dv) begin
              state <= mpf_pkg::MPF_ST_IDLE;
              // errored, odd-length, short or bad-fcs frames leave no trace
              pause_valid <= !frame_err && !nib_odd && crc == `MPF_CRC_GOOD // [RULE_03]
                             && byte_idx >= `MPF_MIN_FRAME
                             && hdr_ok // [RULE_02]
                             && (da_sa1_ok || da_mc_ok); // [RULE_01]
            end else begin
              crc <= crc_nib(crc, pin_s2.d);
              if (pin_s2.er) begin
                frame_err <= 1'b1; // [RULE_03]
              end
              nib_odd <= ~nib_odd;
              if (!nib_odd) begin
                nib_lo <= pin_s2.d;
              end else begin
                if (byte_idx != 11'h7FF) begin
                  byte_idx <= byte_idx + 11'h001;
                end
                // destination, source, type, opcode, pause time in turn
                if (byte_idx < 11'h006) begin // [RULE_04]
                  if (rx_byte != sa1[{byte_idx[2:0], 3'b000} +: 8]) begin
                    da_sa1_ok <= 1'b0; // [RULE_01]
                  end
                  if (rx_byte != mc_addr[47 - {byte_idx[2:0], 3'b000} -: 8]) begin
                    da_mc_ok <= 1'b0; // [RULE_01]
                  end
                end
                unique case (byte_idx)
                  11'h00C: if (rx_byte != TYPE_CTRL[15:8]) hdr_ok <= 1'b0; // [RULE_02]
                  11'h00D: if (rx_byte != TYPE_CTRL[7:0]) hdr_ok <= 1'b0; // [RULE_02]
                  11'h00E: if (rx_byte != OPC_PAUSE[15:8]) hdr_ok <= 1'b0; // [RULE_02]
                  11'h00F: if (rx_byte != OPC_PAUSE[7:0]) hdr_ok <= 1'b0; // [RULE_02]
                  11'h010: ptime_rx[15:8] <= rx_byte; // [RULE_04]
                  `MPF_HDR_LAST: ptime_rx[7:0] <= rx_byte; // [RULE_04]
                  default: ;
                endcase
              end
            end
          end
          mpf_pkg::MPF_ST_DROP: begin
            if (!pin_s2.dv) begin
              state <= mpf_pkg::MPF_ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // pause timer
  logic load;
  logic count_en;
  logic [QW-1:0] quanta_cnt;
  logic tick;
  logic zero_evt;

  assign load = pause_valid && cfg_fdx; // [RULE_06] [RULE_07]
  // with the enable set, counting waits for the transmitter to go quiet
  assign count_en = pause_time != 16'h0000 && (!cfg_pause_en || !tx_active); // [RULE_10] [RULE_12]
  // a load or a pause restarts the prescaler, so each step is a full quantum
  assign tick = rx_rise && count_en
                && (cfg_retry || quanta_cnt == QW'(QUANTA_CYCLES - 1)); // [RULE_11] [RULE_10]

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      quanta_cnt <= '0;
    end else if (load || !count_en || tick) begin
      quanta_cnt <= '0;
    end else if (rx_rise) begin
      quanta_cnt <= quanta_cnt + QW'(1); // [RULE_10]
    end
  end

  always_comb begin
    next_pause_time = pause_time;
    if (load) begin
      next_pause_time = ptime_rx; // [RULE_05]
    end else if (tick) begin
      // count_en keeps this from running below zero
      next_pause_time = pause_time - 16'h0001; // [RULE_15]
    end
  end

  assign zero_evt = !load && tick && pause_time == 16'h0001; // [RULE_13]

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pause_time <= 16'h0000; // [RULE_15]
      tx_hold <= 1'b0;
    end else begin
      pause_time <= next_pause_time;
      // next value, so the hold drops on the same edge the timer reaches zero
      tx_hold <= cfg_pause_en && next_pause_time != 16'h0000; // [RULE_09]
    end
  end

  // statistics
  // wraps at full scale; software must sample it before it can lap
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pause_stat <= '0;
    end else if (pause_valid) begin
      pause_stat <= pause_stat + STAT_W'(1); // [RULE_14]
    end
  end

  // interrupts: a new event wins over a clear in the same cycle
  always_comb begin
    next_isr = isr & ~icr_clr;
    next_isr[`MPF_INT_PAUSE_RX] = next_isr[`MPF_INT_PAUSE_RX] | pause_valid; // [RULE_08] [RULE_07]
    next_isr[`MPF_INT_PAUSE_ZERO] = next_isr[`MPF_INT_PAUSE_ZERO] | zero_evt; // [RULE_13]
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      isr <= 2'b00;
      irq <= 1'b0;
    end else begin
      isr <= next_isr;
      irq <= |(next_isr & ier_now); // [RULE_08] [RULE_13]
    end
  end

endmodule

// ### mpf_defines.svh
// offsets, field positions, reset values and counts of the pause-frame block
// assumes a 32-bit register port with byte addresses, word aligned
`ifndef MPF_DEFINES_SVH
`define MPF_DEFINES_SVH

// register byte offsets
`define MPF_OFS_CFG 8'h00
`define MPF_OFS_SA1_LO 8'h04
`define MPF_OFS_SA1_HI 8'h08
`define MPF_OFS_PTIME 8'h0C
`define MPF_OFS_ISR 8'h10
`define MPF_OFS_IER 8'h14
`define MPF_OFS_ICR 8'h18
`define MPF_OFS_PSTAT 8'h1C

// configuration bit positions
`define MPF_CFG_FDX 1
`define MPF_CFG_RETRY 12
`define MPF_CFG_PAUSE_EN 13

// interrupt bit positions
`define MPF_INT_PAUSE_RX 12
`define MPF_INT_PAUSE_ZERO 13

// reset values
`define MPF_RST_CFG 32'h0000_0000
`define MPF_RST_SA1 48'h0000_0000_0000
`define MPF_RST_IER 32'h0000_0000

// frame constants
`define MPF_MC_ADDR 48'h0180_C200_0001
`define MPF_TYPE_CTRL 16'h8808
`define MPF_OPC_PAUSE 16'h0001
`define MPF_NIB_PRE 4'h5
`define MPF_NIB_SFD 4'hD
`define MPF_CRC_INIT 32'hFFFF_FFFF
`define MPF_CRC_POLY 32'hEDB8_8320
`define MPF_CRC_GOOD 32'hDEBB_20E3
`define MPF_MIN_FRAME 11'h040
`define MPF_HDR_LAST 11'h011

// 512 bit times in nibble mode, counted in receive clock cycles
`define MPF_QUANTA_RX_CLKS 128
`define MPF_STAT_W 16

`endif

// ### mpf_pkg.sv
// types shared by the pause-frame block
// assumes mpf_defines.svh carries every number
package mpf_pkg;

  // one sampled nibble of the receive side
  typedef struct packed {
    logic clk;
    logic dv;
    logic er;
    logic [3:0] d;
  } mpf_mii_t;

  typedef enum logic [1:0] {
    MPF_ST_IDLE,
    MPF_ST_PRE,
    MPF_ST_BODY,
    MPF_ST_DROP
  } mpf_state_t;

endpackage

// ### mpf_pause_ctrl_asserts.sv
// port-level checks of the pause block: read timing, transmit hold, interrupt
// assumes one clk_sys domain and frames marked by the raw mii_rx_dv pin
`timescale 1ns/1ps
module mpf_pause_ctrl_asserts (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic mii_rx_dv,
  input wire logic tx_active,
  input wire logic tx_hold,
  input wire logic irq
);
  // cycles since the link last carried a frame; results land about ten later
  logic [4:0] idle;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) idle <= 5'h1F;
    else if (mii_rx_dv) idle <= 5'h00;
    else if (idle != 5'h1F) idle <= idle + 5'h01;
  end
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_calm;
    !reg_wr && !$past(reg_wr) && idle > 5'h14;
  endsequence
  sequence s_busy;
    (mii_rx_dv && !reg_wr) [*6];
  endsequence
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
  endproperty
  property p_rst_out;
    $rose(reset_n) |-> !tx_hold && !irq;
  endproperty
  property p_rst_rd;
    $rose(reset_n) |-> reg_rdata == 32'h0000_0000;
  endproperty
  property p_hold_rise;
    $rose(tx_hold) |-> idle <= 5'h14 || $past(reg_wr) || $past(reg_wr, 2);
  endproperty
  property p_hold_keep;
    tx_hold && tx_active ##0 s_calm ##1 tx_active && !reg_wr |-> tx_hold;
  endproperty
  property p_hold_fall;
    $fell(tx_hold) |-> !$past(tx_active) || !$past(tx_active, 2) || $past(reg_wr)
      || $past(reg_wr, 2) || idle <= 5'h14;
  endproperty
  property p_irq_keep;
    irq && !reg_wr |=> irq;
  endproperty
  property p_rx_quiet;
    s_busy |-> !$rose(tx_hold);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its cycle");
  a_rst_out: assert property (p_rst_out)
    else $error("hold or irq high after reset");
  a_rst_rd: assert property (p_rst_rd)
    else $error("read data high after reset");
  a_hold_rise: assert property (p_hold_rise)
    else $error("hold rose without a frame or write");
  a_hold_keep: assert property (p_hold_keep)
    else $error("hold dropped while transmitting");
  a_hold_fall: assert property (p_hold_fall)
    else $error("countdown ran while transmitting");
  a_irq_keep: assert property (p_irq_keep)
    else $error("irq dropped without a write");
  a_rx_quiet: assert property (p_rx_quiet)
    else $error("hold rose in mid frame");
endmodule
bind mpf_pause_ctrl mpf_pause_ctrl_asserts u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mii_rx_dv(mii_rx_dv),
  .tx_active(tx_active), .tx_hold(tx_hold), .irq(irq));

// ### mpf_phy_model.sv
// phy side model: drives the mii receive pins with whole frames
// assumes the receive clock runs free, as the pause countdown needs it
`timescale 1ns/1ps
`include "mpf_defines.svh"
module mpf_phy_model (
  output logic mii_rx_clk,
  output logic mii_rx_dv,
  output logic mii_rx_er,
  output logic [3:0] mii_rxd
);
  logic [7:0] frm [0:63];
  logic [31:0] c;
  initial begin
    mii_rx_clk = 1'b0;
    #137;
    forever #400 mii_rx_clk = ~mii_rx_clk;
  end
  initial begin
    mii_rx_dv = 1'b0;
    mii_rx_er = 1'b0;
    mii_rxd = 4'h0;
  end
  // da in wire order; pad stays zero; bad flips one fcs bit
  task automatic send(input logic [47:0] da, input logic [15:0] ty, input logic [15:0] op,
                      input logic [15:0] pt, input logic bad, input logic er);
    for (int i = 0; i < 64; i++) frm[i] = 8'h00;
    for (int i = 0; i < 6; i++) begin
      frm[i] = da[47 - 8 * i -: 8];
      frm[6 + i] = 8'h20 + 8'(i);
    end
    {frm[12], frm[13], frm[14], frm[15], frm[16], frm[17]} = {ty, op, pt};
    c = `MPF_CRC_INIT;
    for (int i = 0; i < 60; i++) begin
      c = c ^ {24'h00_0000, frm[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ `MPF_CRC_POLY : c >> 1;
    end
    c = ~c ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) frm[60 + i] = c[8 * i +: 8];
    for (int n = 0; n < 144; n++) begin
      @(posedge mii_rx_clk);
      mii_rx_dv <= 1'b1;
      mii_rx_er <= er && n == 90;
      if (n < 16) mii_rxd <= n < 15 ? `MPF_NIB_PRE : `MPF_NIB_SFD;
      else mii_rxd <= n[0] ? frm[(n - 16) / 2][7:4] : frm[(n - 16) / 2][3:0];
    end
    @(posedge mii_rx_clk);
    mii_rx_dv <= 1'b0;
    mii_rx_er <= 1'b0;
    mii_rxd <= ~mii_rxd;
    repeat (2) @(posedge mii_rx_clk);
  endtask
endmodule

// ### mpf_pause_ctrl_tb_top.sv
// testbench of the pause block: register port, frames, countdown, interrupts
// assumes the phy model and a prescaler shortened to QC receive clocks
`timescale 1ns/1ps
`include "mpf_defines.svh"
module mpf_pause_ctrl_tb_top;
  localparam int QC = 4;
  logic clk_sys, reset_n, reg_wr, reg_rd, tx_active, tx_hold, irq;
  logic mii_rx_clk, mii_rx_dv, mii_rx_er;
  logic [3:0] mii_rxd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  int fail_count, tests_run, cyc;
  logic [7:0] ofs [0:8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
  mpf_pause_ctrl #(.QUANTA_CYCLES(QC), .STAT_W(16)) dut (.clk_sys(clk_sys),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mii_rx_clk(mii_rx_clk), .mii_rx_dv(mii_rx_dv),
    .mii_rx_er(mii_rx_er), .mii_rxd(mii_rxd), .tx_active(tx_active), .tx_hold(tx_hold),
    .irq(irq));
  mpf_phy_model phy (.mii_rx_clk(mii_rx_clk), .mii_rx_dv(mii_rx_dv),
    .mii_rx_er(mii_rx_er), .mii_rxd(mii_rxd));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] time %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask
  task automatic mc(input logic [15:0] pt);
    phy.send(`MPF_MC_ADDR, `MPF_TYPE_CTRL, `MPF_OPC_PAUSE, pt, 1'b0, 1'b0);
  endtask
  // stop transmitting, then count cycles until the hold lifts
  task automatic run_down(input int lim);
    @(posedge clk_sys);
    tx_active <= 1'b0;
    cyc = 0;
    while (tx_hold !== 1'b0) begin
      @(posedge clk_sys);
      #1;
      cyc++;
      if (cyc > lim) begin
        fail_count++;
        finish_test();
      end
    end
  endtask
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    tx_active = 1'b1;
    fail_count = 0;
    tests_run = 0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    foreach (ofs[i]) rd(ofs[i], 32'h0000_0000);
    wr(`MPF_OFS_CFG, 32'h0000_2002);
    wr(`MPF_OFS_IER, 32'h0000_3000);
    wr(`MPF_OFS_PTIME, 32'h0000_1234);
    wr(8'h20, 32'h0000_FFFF);
    rd(`MPF_OFS_PTIME, 32'h0000_0000);
    rd(`MPF_OFS_IER, 32'h0000_3000);
    mc(16'h0005);
    rd(`MPF_OFS_PTIME, 32'h0000_0005);
    rd(`MPF_OFS_ISR, 32'h0000_1000);
    check({irq, tx_hold}, 32'h0000_0003);
    rd(`MPF_OFS_PSTAT, 32'h0000_0001);
    wr(`MPF_OFS_ICR, 32'h0000_1000);
    // wrong type, wrong opcode, bad fcs, receive error, foreign address
    for (int i = 0; i < 5; i++) begin
      phy.send(i == 4 ? 48'h0180_C200_0002 : `MPF_MC_ADDR, i == 0 ? 16'h8809 : `MPF_TYPE_CTRL,
               i == 1 ? 16'h0002 : `MPF_OPC_PAUSE, 16'h0009, i == 2, i == 3);
      rd(`MPF_OFS_PTIME, 32'h0000_0005);
      rd(`MPF_OFS_ISR, 32'h0000_0000);
    end
    rd(`MPF_OFS_PSTAT, 32'h0000_0001);
    wr(`MPF_OFS_SA1_LO, 32'h3322_1102);
    wr(`MPF_OFS_SA1_HI, 32'h0000_5544);
    wr(`MPF_OFS_IER, 32'h0000_2000);
    phy.send(48'h0211_2233_4455, `MPF_TYPE_CTRL, `MPF_OPC_PAUSE, 16'h0102, 1'b0, 1'b0);
    rd(`MPF_OFS_PTIME, 32'h0000_0102);
    rd(`MPF_OFS_ISR, 32'h0000_1000);
    check({irq, tx_hold}, 32'h0000_0001);
    wr(`MPF_OFS_ICR, 32'h0000_3000);
    mc(16'h0002);
    run_down(400);
    check(cyc >= 16 * QC - 16 && cyc <= 16 * QC + 16, 32'h0000_0001);
    rd(`MPF_OFS_ISR, 32'h0000_3000);
    check({irq, tx_hold}, 32'h0000_0002);
    wr(`MPF_OFS_ICR, 32'h0000_3000);
    wr(`MPF_OFS_CFG, 32'h0000_3002);
    tx_active <= 1'b1;
    mc(16'h0004);
    run_down(200);
    check(cyc >= 24 && cyc <= 44, 32'h0000_0001);
    rd(`MPF_OFS_PTIME, 32'h0000_0000);
    wr(`MPF_OFS_ICR, 32'h0000_3000);
    wr(`MPF_OFS_CFG, 32'h0000_0002);
    tx_active <= 1'b1;
    mc(16'h0002);
    rd(`MPF_OFS_PTIME, 32'h0000_0002);
    check({irq, tx_hold}, 32'h0000_0000);
    repeat (16 * QC + 40) @(posedge clk_sys);
    rd(`MPF_OFS_PTIME, 32'h0000_0000);
    rd(`MPF_OFS_ISR, 32'h0000_3000);
    wr(`MPF_OFS_ICR, 32'h0000_3000);
    wr(`MPF_OFS_CFG, 32'h0000_2000);
    mc(16'h0007);
    rd(`MPF_OFS_PTIME, 32'h0000_0000);
    check({irq, tx_hold}, 32'h0000_0000);
    rd(`MPF_OFS_ISR, 32'h0000_1000);
    rd(`MPF_OFS_PSTAT, 32'h0000_0006);
    finish_test();
  end
endmodule
